//--- opc_checker_sva.sv
// Timing checks of the output port block.
// Assumes the one-cycle register port and synchronous reset.
`default_nettype none
module opc_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register port
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // Camera signals
   input wire logic        exposure_active,
   input wire logic        accepts_trigger,
   // Output port pins
   input wire logic [3:0]  port_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] age;
   // Cycles since reset, holding at 2; 3 once anything was written
   always_ff @(posedge clk) begin
      if (rst) age <= 2'd0;
      else if (reg_write) age <= 2'd3;
      else if (age < 2'd2) age <= age + 2'd1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data not idle");
   AST_MON: assert property ($past(reg_read && reg_addr == 8'h10)
      |-> reg_rdata == {28'h0, $past(port_out)}) else $error("monitor read wrong");
   AST_PAR_RD: assert property ($past(reg_read && reg_addr == 8'h00)
      |-> reg_rdata == {28'h0, $past(port_out)}) else $error("parallel read wrong");
   AST_UPPER: assert property ($past(reg_addr) != 8'h04 |-> reg_rdata[31:4] == 28'h0)
      else $error("upper read bits set");
   AST_PAR_WR: assert property (reg_write && reg_addr == 8'h00
      |-> ##2 port_out == $past(reg_wdata[3:0], 2)) else $error("parallel write lost");
   AST_WR_HOLD: assert property (reg_write && reg_addr == 8'h00 ##1 !reg_write [*2]
      |=> port_out == $past(reg_wdata[3:0], 3)) else $error("pins not held");
   AST_DFLT: assert property (age == 2'd2
      |-> port_out == {2'b00, $past(accepts_trigger), $past(exposure_active)})
      else $error("default routing wrong");
   AST_RST: assert property ($past(rst) |-> port_out == 4'h0)
      else $error("pins not low after reset");
endmodule // opc_checker
bind opc_output_port_control opc_checker i_opc_checker (.clk(clk), .rst(rst),
   .reg_write(reg_write), .reg_read(reg_read), .exposure_active(exposure_active),
   .accepts_trigger(accepts_trigger), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .port_out(port_out));
`default_nettype wire

//--- opc_ext_load.sv
// Load wired to the four output pins.
// Assumes each pin drives a load that conducts while high.
`default_nettype none
module opc_ext_load (
   // Pins and load state
   input  wire logic [3:0] port_out,
   output wire logic [3:0] load_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // High pin conducts, low pin does not
   assign load_on = port_out;
endmodule // opc_ext_load
`default_nettype wire

//--- opc_output_port_control.v
// Control of four digital output ports with per-port source, invert and level,
// a per-port monitor and a parallel output word.
// Assumes a one-cycle register port, inputs synchronous to clk and a synchronous reset.
//
// Overview of operation
// - User level is applied before the inverter on a user settable port.
// - Monitor register reports each port's present pin level, low or high.
// - Parallel output word is 32 bits; only the four low bits matter.
// - Writing parallel word drives each port high for 1, low for 0.
// - Reading parallel word returns present port levels in its four low bits.
// - Port state reads finish well within 250 microseconds.
// - Output level writes take effect well within 200 microseconds.
// - Input read then output write completes in under one millisecond.
// - Each port selects exposure active, accepts trigger, or user settable source.
// - After reset port 0 carries exposure active, port 1 accepts trigger.
// - Invert control false passes the signal, true inverts it at the pin.
// - User level per port selects low or high, changeable any time.
`include "opc_regs.vh"
`default_nettype none

module opc_output_port_control #(
   parameter ADDR_W = 8,
   parameter DATA_W = 32
) (
   // Clock and reset
   input  wire                clk,
   input  wire                rst,
   // Register port
   input  wire [ADDR_W-1:0]   reg_addr,
   input  wire [DATA_W-1:0]   reg_wdata,
   input  wire                reg_write,
   input  wire                reg_read,
   output reg  [DATA_W-1:0]   reg_rdata,
   // Camera signals
   input  wire                exposure_active,
   input  wire                accepts_trigger,
   // Output port pins
   output wire [3:0]          port_out
);

   // ************************************************************
   // Configuration registers
   // ************************************************************

   reg  [`OPC_SRC_ALL_W-1:0]  port_source_select;
   reg  [`OPC_PORTS-1:0]      port_invert_control;
   reg  [`OPC_PORTS-1:0]      user_port_level;
   wire [`OPC_PORTS-1:0]      pin_level;
   reg  [DATA_W-1:0]          next_rdata;

   // Address match on the low address bits
   function hit;
      input [ADDR_W-1:0] addr;
      input [7:0]        target;
      begin
         hit = (addr[7:0] == target);
      end
   endfunction

   // Register writes; parallel word forces user mode so the pin shows the bit
   always @(posedge clk) begin
      if (rst) begin
         port_source_select  <= `OPC_SRC_RESET;
         port_invert_control <= `OPC_INVERT_RESET;
         user_port_level     <= `OPC_LEVEL_RESET;
      end else if (reg_write) begin
         if (hit(reg_addr, `OPC_ADDR_PARALLEL)) begin
            port_source_select <= `OPC_SRC_ALL_USER;
            // Pre-invert so bit n lands on pin n as written
            user_port_level    <= reg_wdata[3:0] ^ port_invert_control;
         end
         if (hit(reg_addr, `OPC_ADDR_SOURCE)) begin
            port_source_select <= reg_wdata[`OPC_SRC_ALL_W-1:0];
         end
         if (hit(reg_addr, `OPC_ADDR_INVERT)) begin
            port_invert_control <= reg_wdata[3:0];
         end
         if (hit(reg_addr, `OPC_ADDR_LEVEL)) begin
            user_port_level <= reg_wdata[3:0];
         end
      end
   end

   // ************************************************************
   // Port stages
   // ************************************************************

   // One stage per port, selector field n for port n
   genvar i;
   generate
      for (i = 0; i < `OPC_PORTS; i = i + 1) begin : g_port
         opc_port_stage u_stage (
            .clk                 (clk),
            .rst                 (rst),
            .port_source_select  (port_source_select[i*`OPC_SRC_W +: `OPC_SRC_W]),
            .port_invert_control (port_invert_control[i]),
            .user_port_level     (user_port_level[i]),
            .exposure_active     (exposure_active),
            .accepts_trigger     (accepts_trigger),
            .pin                 (pin_level[i])
         );
      end
   endgenerate

   // Pins straight from the stage flip-flops
   assign port_out = pin_level;

   // ************************************************************
   // Read path
   // ************************************************************

   // Read data select; unmapped addresses read zero
   always @* begin
      next_rdata = {DATA_W{1'b0}};
      if (hit(reg_addr, `OPC_ADDR_PARALLEL)) begin
         next_rdata[3:0] = pin_level;
      end else if (hit(reg_addr, `OPC_ADDR_SOURCE)) begin
         next_rdata[`OPC_SRC_ALL_W-1:0] = port_source_select;
      end else if (hit(reg_addr, `OPC_ADDR_INVERT)) begin
         next_rdata[3:0] = port_invert_control;
      end else if (hit(reg_addr, `OPC_ADDR_LEVEL)) begin
         next_rdata[3:0] = user_port_level;
      end else if (hit(reg_addr, `OPC_ADDR_MONITOR)) begin
         next_rdata[3:0] = pin_level;
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= {DATA_W{1'b0}};
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= {DATA_W{1'b0}};
      end
   end

endmodule // opc_output_port_control

`default_nettype wire

//--- opc_port_stage.v
// One output port: source selection, inverter and the pin flip-flop.
// Assumes camera signals synchronous to clk and configuration held in the parent.
`include "opc_regs.vh"
`default_nettype none

module opc_port_stage (
   // Clock and reset
   input  wire                    clk,
   input  wire                    rst,
   // Configuration
   input  wire [`OPC_SRC_W-1:0]   port_source_select,
   input  wire                    port_invert_control,
   input  wire                    user_port_level,
   // Camera signals
   input  wire                    exposure_active,
   input  wire                    accepts_trigger,
   // Pin
   output reg                     pin
);

   // ************************************************************
   // Source selection
   // ************************************************************

   // Picks the level ahead of the inverter
   function pick_source;
      input [`OPC_SRC_W-1:0] sel;
      input                  expo;
      input                  trig;
      input                  user;
      begin
         case (sel)
            `OPC_SRC_EXPOSURE: pick_source = expo;
            `OPC_SRC_TRIGGER:  pick_source = trig;
            `OPC_SRC_USER:     pick_source = user;
            default:           pick_source = 1'b0;
         endcase
      end
   endfunction

   wire selected;
   wire next_pin;

   // Selected signal, user level included, then inverter
   assign selected = pick_source(port_source_select, exposure_active,
                                 accepts_trigger, user_port_level);
   assign next_pin = selected ^ port_invert_control;

   // ************************************************************
   // Pin register
   // ************************************************************

   // Registered pin level
   always @(posedge clk) begin
      if (rst) begin
         pin <= `OPC_PIN_RESET;
      end else begin
         pin <= next_pin;
      end
   end

endmodule // opc_port_stage

`default_nettype wire

//--- opc_regs.vh
// Register map, field layout, reset values and timing figures of the output port block.
// Assumes inclusion by bare name from the design files of this block only.
`ifndef OPC_REGS_VH
`define OPC_REGS_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define OPC_ADDR_PARALLEL  8'h00
`define OPC_ADDR_SOURCE    8'h04
`define OPC_ADDR_INVERT    8'h08
`define OPC_ADDR_LEVEL     8'h0c
`define OPC_ADDR_MONITOR   8'h10

// ************************************************************
// Field layout
// ************************************************************
`define OPC_PORTS          4
`define OPC_SRC_W          2
`define OPC_SRC_ALL_W      8

// ************************************************************
// Source selector codes
// ************************************************************
`define OPC_SRC_EXPOSURE   2'h0
`define OPC_SRC_TRIGGER    2'h1
`define OPC_SRC_USER       2'h2
`define OPC_SRC_NONE       2'h3
`define OPC_SRC_ALL_USER   8'haa

// ************************************************************
// Reset values
// ************************************************************
`define OPC_SRC_RESET      8'ha4
`define OPC_INVERT_RESET   4'h0
`define OPC_LEVEL_RESET    4'h0
`define OPC_PIN_RESET      1'b0

// ************************************************************
// Timing figures
// ************************************************************
`define OPC_CLK_PERIOD_PS  4000
`define OPC_READ_TIME_NS   250000
`define OPC_WRITE_TIME_NS  200000
`define OPC_LOOP_TIME_NS   1000000
`define OPC_READ_CYCLES    ((`OPC_READ_TIME_NS * 1000) / `OPC_CLK_PERIOD_PS)
`define OPC_WRITE_CYCLES   ((`OPC_WRITE_TIME_NS * 1000) / `OPC_CLK_PERIOD_PS)
`define OPC_LOOP_CYCLES    ((`OPC_LOOP_TIME_NS * 1000) / `OPC_CLK_PERIOD_PS)

`endif

//--- tb_top.sv
// Self-checking bench of the output port block.
// Assumes design, load model and checker compiled first.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, expo = 0, trig = 0;
   logic [7:0]  reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata;
   logic [3:0]  port_out, load_on;
   int err_count = 0, n_tests = 0;
   opc_output_port_control i_opc_output_port_control (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .exposure_active(expo),
      .accepts_trigger(trig), .port_out(port_out));
   opc_ext_load i_opc_ext_load (.port_out(port_out), .load_on(load_on));
   initial forever #2 clk = ~clk;
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_write <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_read <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 0;
      #1 chk("rdata", exp, reg_rdata);
   endtask
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   initial begin
      #20000;
      err_count++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      rd(8'h04, 32'ha4);
      rd(8'h08, 32'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {trig, expo} <= i[1:0];
         repeat (2) @(posedge clk);
         #1 chk("pins", {30'h0, i[1:0]}, {28'h0, load_on});
      end
      wr(8'h08, 32'h1);
      chk("pins", 32'h2, {28'h0, load_on});
      // Trigger signal dropped on an edge like every other input
      @(posedge clk);
      trig <= 0;
      wr(8'h0c, 32'h4);
      for (int c = 0; c < 4; c++) begin
         wr(8'h04, {24'h0, 2'h2, c[1:0], 4'h4});
         chk("pins", {29'h0, c == 0 || c == 2, 2'h0}, {28'h0, load_on});
      end
      wr(8'h04, 32'haa);
      wr(8'h08, 32'h5);
      wr(8'h0c, 32'h3);
      chk("pins", 32'h6, {28'h0, load_on});
      rd(8'h10, 32'h6);
      for (int n = 0; n < 4; n++) begin
         wr(8'h00, 32'hffff_fff0 | (32'h1 << n));
         rd(8'h00, 32'h1 << n);
      end
      wr(8'h08, 32'h0);
      rd(8'h10, 32'hd);
      wr(8'h20, 32'hf);
      rd(8'h20, 32'h0);
      rd(8'h00, 32'hd);
      @(posedge clk);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      rd(8'h04, 32'ha4);
      // Exposure high, trigger low: only port 0 lit after reset
      chk("pins", 32'h1, {28'h0, load_on});
      complete_run;
   end
endmodule // tb_top
`default_nettype wire
